// *** rtl/fblp_lock_protect.sv ***
// Per-block lock bit store and write/erase protection gate for program flash.
`timescale 1ns/10ps
// Notes on behaviour
// - One retained lock bit per program block.
// - Protection applies only while override is clear.
// - Locked blocks reject program and erase.
// - Lock program command clears lock bit.
// - Erasing a block sets its lock bit.
// - No command sets a lock bit alone.
// - Read lock status returns stored bit.
// - Override unlocks all, stored bits unchanged.
// - Clearing override resumes with retained bits.
// - Erase under override ignores lock bit.
// - Completed erase leaves lock bit at one.
// - Auto erase completion clears override.
// - Program or erase completion clears override.
// - Entering suspend clears override.
// - Sequence error clears override.
// - Leaving rewrite mode clears override.
// - Stopping flash clears override.
// - Sequence reset clears override.
module fblp_lock_protect #(
  parameter int unsigned blocks = fblp_pkg::fblp_default_blocks,
  parameter int unsigned blk_w = (blocks > 1) ? $clog2(blocks) : 1
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire fblp_pkg::fblp_cmd_t cmd_in,
  input wire logic [blk_w-1:0] cmd_block_in,
  input wire logic override_wr_in,
  input wire logic override_val_in,
  input wire fblp_pkg::fblp_ctl_wr_t ctl_wr_in,
  input wire fblp_pkg::fblp_seq_evt_t seq_evt_in,
  input wire logic [blocks-1:0] lock_init_in,
  input wire logic lock_init_load_in,
  output logic lock_override_out,
  output logic flash_ready_flag_out,
  output logic op_start_out,
  output logic op_erase_out,
  output logic [blk_w-1:0] op_block_out,
  output logic op_rejected_out,
  output logic lock_status_valid_out,
  output logic lock_status_out,
  output logic [blocks-1:0] lock_bits_out
);
  import fblp_pkg::*;

  initial begin
    if (blocks < 1 || (1 << blk_w) < blocks) begin
      $error("fblp_lock_protect: block count and index width do not fit");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock bit store. The bits model nonvolatile cells, so they are not touched by
  // reset; the loader port restores the retained image after power-up.
  logic [blocks-1:0] lock_bits;
  logic [blocks-1:0] next_lock_bits;
  logic lock_override;
  fblp_state_t state;
  fblp_state_t next_state;
  logic busy_erase;
  logic [blk_w-1:0] busy_block;

  wire logic cmd_is_pe = cmd_valid_in && state == fblp_st_ready &&
    (cmd_in == fblp_cmd_program || cmd_in == fblp_cmd_erase);
  wire logic target_locked = lock_bits[cmd_block_in] == fblp_lock_locked;
  // Override bypasses the check without altering stored bits.
  wire logic protect_on = lock_override == fblp_override_off;
  wire logic cmd_refused = cmd_is_pe && protect_on && target_locked;
  wire logic cmd_accept = cmd_is_pe && !cmd_refused;
  wire logic op_done = seq_evt_in.prog_done || seq_evt_in.erase_done;
  wire logic lock_pgm = cmd_valid_in && state == fblp_st_ready &&
    cmd_in == fblp_cmd_lock_program;

  // Apart from an image load, only lock-program can lower a bit and only an erase can raise one.
  always_comb begin
    next_lock_bits = lock_bits;
    if (lock_pgm) begin
      next_lock_bits[cmd_block_in] = fblp_lock_locked;
    end
    if (state == fblp_st_busy && busy_erase && seq_evt_in.erase_done) begin
      next_lock_bits[busy_block] = fblp_lock_unlocked;
    end
  end

  always_ff @(posedge clock_in) begin
    if (lock_init_load_in) begin
      lock_bits <= lock_init_in;
    end else begin
      lock_bits <= next_lock_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Override flag. Every automatic clear outranks a software set in the same
  // cycle, so a bypass never survives past the operation it was armed for.
  wire logic clr_done = state == fblp_st_busy && op_done;
  wire logic clr_susp = state == fblp_st_busy && seq_evt_in.suspend_entered;
  wire logic clr_err = seq_evt_in.seq_error;
  wire logic clr_rew = ctl_wr_in.rewrite_enable_wr && !ctl_wr_in.rewrite_enable_val;
  wire logic clr_stop = ctl_wr_in.stop_wr && ctl_wr_in.stop_val;
  wire logic clr_srst = ctl_wr_in.seq_reset_wr && ctl_wr_in.seq_reset_val;
  wire logic clr_any = clr_done || clr_susp || clr_err || clr_rew || clr_stop || clr_srst;
  wire logic next_lock_override = clr_any ? fblp_override_off :
    (override_wr_in ? override_val_in : lock_override);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lock_override <= fblp_override_off;
    end else begin
      lock_override <= next_lock_override;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready/busy sequencing. A refused command spends one busy cycle so software
  // sees the usual busy-to-ready edge, but never reaches the array.
  wire logic abort = clr_err || clr_stop || clr_srst;

  always_comb begin
    next_state = state;
    unique case (state)
      fblp_st_ready: begin
        if (cmd_accept) begin
          next_state = fblp_st_busy;
        end else if (cmd_refused) begin
          next_state = fblp_st_reject;
        end
      end
      fblp_st_busy: begin
        if (op_done || seq_evt_in.suspend_entered || abort) begin
          next_state = fblp_st_ready;
        end
      end
      fblp_st_reject: begin
        next_state = fblp_st_ready;
      end
      default: begin
        next_state = fblp_st_ready;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= fblp_st_ready;
      busy_erase <= 1'b0;
      busy_block <= '0;
      op_start_out <= 1'b0;
      op_erase_out <= 1'b0;
      op_block_out <= '0;
      op_rejected_out <= 1'b0;
      lock_status_valid_out <= 1'b0;
      lock_status_out <= 1'b0;
    end else begin
      state <= next_state;
      op_start_out <= cmd_accept;
      op_rejected_out <= cmd_refused;
      lock_status_valid_out <= cmd_valid_in && state == fblp_st_ready &&
        cmd_in == fblp_cmd_read_lock;
      if (cmd_valid_in && state == fblp_st_ready && cmd_in == fblp_cmd_read_lock) begin
        lock_status_out <= lock_bits[cmd_block_in];
      end
      if (cmd_accept) begin
        busy_erase <= cmd_in == fblp_cmd_erase;
        busy_block <= cmd_block_in;
        op_erase_out <= cmd_in == fblp_cmd_erase;
        op_block_out <= cmd_block_in;
      end
    end
  end

  assign lock_override_out = lock_override;
  assign flash_ready_flag_out = state == fblp_st_ready;
  assign lock_bits_out = lock_bits;
endmodule : fblp_lock_protect

// *** rtl/fblp_pkg.sv ***
// Package with constants and carrier types for the flash block lock protection logic.
package fblp_pkg;
  localparam int unsigned fblp_default_blocks = 4;
  localparam logic fblp_lock_locked = 1'b0;
  localparam logic fblp_lock_unlocked = 1'b1;
  localparam logic fblp_override_off = 1'b0;

  // Command codes presented with a command strobe.
  typedef enum logic [2:0] {
    fblp_cmd_program = 3'h1,
    fblp_cmd_erase = 3'h2,
    fblp_cmd_lock_program = 3'h3,
    fblp_cmd_read_lock = 3'h4
  } fblp_cmd_t;

  // Events reported by the command sequencer.
  typedef struct packed {
    logic prog_done;
    logic erase_done;
    logic suspend_entered;
    logic seq_error;
  } fblp_seq_evt_t;

  // Software control writes that affect the override flag.
  typedef struct packed {
    logic rewrite_enable_wr;
    logic rewrite_enable_val;
    logic stop_wr;
    logic stop_val;
    logic seq_reset_wr;
    logic seq_reset_val;
  } fblp_ctl_wr_t;

  // State machine encoding, one-hot.
  typedef enum logic [2:0] {
    fblp_st_ready = 3'h1,
    fblp_st_busy = 3'h2,
    fblp_st_reject = 3'h4
  } fblp_state_t;
endpackage : fblp_pkg

// *** testbench/fblp_lock_protect_props.sv ***
// Assertion checker for the flash block lock protection logic.
`timescale 1ns/10ps
module fblp_lock_protect_props #(parameter int unsigned blocks = 4, blk_w = 2) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire fblp_pkg::fblp_cmd_t cmd_in,
  input wire logic [blk_w-1:0] cmd_block_in,
  input wire fblp_pkg::fblp_ctl_wr_t ctl_wr_in,
  input wire fblp_pkg::fblp_seq_evt_t seq_evt_in,
  input wire logic lock_init_load_in,
  input wire logic lock_override_out,
  input wire logic flash_ready_flag_out,
  input wire logic op_start_out,
  input wire logic op_rejected_out,
  input wire logic lock_status_out,
  input wire logic [blocks-1:0] lock_bits_out
);
  import fblp_pkg::*;
  wire logic tk = cmd_valid_in && flash_ready_flag_out;
  wire logic sel = lock_bits_out[cmd_block_in];
  wire logic open = lock_override_out || sel;
  wire logic pe = tk && cmd_in inside {fblp_cmd_program, fblp_cmd_erase};
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  chk_locked_reject: assert property (pe && !open |=> op_rejected_out)
    else $error("locked op taken");
  chk_open_accept: assert property (pe && open |=> op_start_out)
    else $error("open op refused");
  chk_lock_program: assert property (tk && cmd_in == fblp_cmd_lock_program
    |=> !lock_bits_out[$past(cmd_block_in)]) else $error("lock bit not cleared");
  chk_read_status: assert property (tk && cmd_in == fblp_cmd_read_lock
    |=> lock_status_out == $past(sel)) else $error("status wrong");
  chk_done_clear: assert property (!flash_ready_flag_out && !op_rejected_out && seq_evt_in[3:1] != 3'h0
    |=> flash_ready_flag_out && !lock_override_out) else $error("done kept override");
  chk_event_clear: assert property (seq_evt_in[0] || ctl_wr_in[3:2] == 2'h3
    || ctl_wr_in[1:0] == 2'h3 || ctl_wr_in[5:4] == 2'h2 |=> !lock_override_out)
    else $error("event kept override");
  chk_reject_ready: assert property (op_rejected_out
    |-> !flash_ready_flag_out ##1 flash_ready_flag_out) else $error("reject ready wrong");
  // Bits may only move on a taken command, an erase end or an image load.
  chk_bits_hold: assert property (!tk && !seq_evt_in[2] && !lock_init_load_in
    |=> $stable(lock_bits_out)) else $error("lock bits moved");
endmodule : fblp_lock_protect_props
bind fblp_lock_protect fblp_lock_protect_props #(.blocks(blocks), .blk_w(blk_w)) i_props (.*);

// *** testbench/fblp_lock_protect_tb_top.sv ***
// Self-checking testbench for the flash block lock protection logic.
`timescale 1ns/10ps
module fblp_lock_protect_tb_top;
  import fblp_pkg::*;
  logic c = 1'b0;
  logic r = 1'b0;
  logic v = 1'b0;
  logic w = 1'b0;
  logic ld = 1'b0;
  fblp_cmd_t k = fblp_cmd_program;
  logic [1:0] b = 2'h0;
  fblp_ctl_wr_t cw = 6'h0;
  fblp_seq_evt_t e = 4'h0;
  logic ov, rd, st, rj, sv, ss, oe;
  logic [1:0] ob;
  logic [3:0] lb;
  int fail_count = 0;
  int compares = 0;
  fblp_lock_protect i_fblp_lock_protect (.clock_in(c), .rst_n_in(r), .cmd_valid_in(v),
    .cmd_in(k), .cmd_block_in(b), .override_wr_in(w), .override_val_in(1'b1),
    .ctl_wr_in(cw), .seq_evt_in(e), .lock_init_in(4'h5), .lock_init_load_in(ld),
    .lock_override_out(ov), .flash_ready_flag_out(rd), .op_start_out(st),
    .op_erase_out(oe), .op_block_out(ob), .op_rejected_out(rj),
    .lock_status_valid_out(sv), .lock_status_out(ss), .lock_bits_out(lb));
  ////////////////////////////////////////
  task chk(input string n, input logic [3:0] s, input logic [3:0] x);
    compares++;
    if (s !== x) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task go(input fblp_cmd_t q, input logic [1:0] a);
    @(negedge c);
    k = q;
    b = a;
    v = 1'b1;
    @(negedge c);
    v = 1'b0;
  endtask : go
  // Override writes share this driver, but no call here pairs one with an event pulse.
  task ev(input logic [3:0] q, input logic [5:0] a, input logic o);
    @(negedge c);
    e = q;
    cw = a;
    w = o;
    @(negedge c);
    e = 4'h0;
    cw = 6'h0;
    w = 1'b0;
  endtask : ev
  task t_guard;
    go(fblp_cmd_program, 2'h1);
    chk("reject", {rj, st, rd}, 4'h4);
    ev(4'h0, 6'h0, 1'b1);
    go(fblp_cmd_read_lock, 2'h1);
    chk("status", {sv, ss, ov, lb[1]}, 4'ha);
    go(fblp_cmd_erase, 2'h1);
    chk("bypass", {st, rd, oe}, 4'h5);
    chk("op_block", ob, 4'h1);
    ev(4'h4, 6'h0, 1'b0);
    chk("erased", {ov, rd, lb[1]}, 4'h3);
  endtask : t_guard
  task t_clear;
    go(fblp_cmd_lock_program, 2'h2);
    chk("locked", lb, 4'h3);
    for (int i = 0; i < 6; i++) begin
      ev(4'h0, 6'h0, 1'b1);
      if (i > 3) go(fblp_cmd_program, 2'h3);
      ev(i == 0 ? 4'h1 : i == 4 ? 4'h2 : i == 5 ? 4'h8 : 4'h0,
        i == 1 ? 6'h0c : i == 2 ? 6'h03 : i == 3 ? 6'h20 : 6'h0, 1'b0);
      chk("cleared", {ov, rd}, 4'h1);
    end
    go(fblp_cmd_erase, 2'h2);
    chk("resumed", rj, 4'h1);
  endtask : t_clear
  task wrap_up;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    forever #25 c = ~c;
  end
  initial begin
    repeat (3000) @(posedge c);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (12) @(negedge c);
    r = 1'b1;
    ld = 1'b1;
    @(negedge c);
    ld = 1'b0;
    chk("init", lb, 4'h5);
    t_guard();
    t_clear();
    r = 1'b0;
    @(negedge c);
    r = 1'b1;
    chk("kept", lb, 4'h3);
    wrap_up();
  end
endmodule : fblp_lock_protect_tb_top
